// [verilog/ptcwd_top.sv]
// Purpose: Volatile terminal control register and per-channel switch control.
// Assumes: A serial front end delivers decoded commands and a completion strobe.
// Notes: Lock bits come from non-volatile logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ptcwd_top #(
  parameter bit TWO_CHANNEL = 1'b1,
  parameter bit EIGHT_BIT = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Brown-out reset event pin, asynchronous to clk.
  input wire logic brownoutResetEvent,
  // Command port from the serial front end.
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [ptcwd_pkg::ADDR_W-1:0] cmdAddr,
  input wire logic [ptcwd_pkg::TC_W-1:0] cmdWrData,
  input wire logic cmdDone,
  output logic rdValid,
  output logic [ptcwd_pkg::TC_W-1:0] rdData,
  // Lock state and volatile wiper codes.
  input wire logic ch0Lock,
  input wire logic ch1Lock,
  input wire logic [ptcwd_pkg::CODE_W-1:0] ch0WiperCode,
  input wire logic [ptcwd_pkg::CODE_W-1:0] ch1WiperCode,
  // Terminal switch controls and general call acceptance.
  output ptcwd_pkg::ptcwd_switch_type ch0Switch,
  output ptcwd_pkg::ptcwd_switch_type ch1Switch,
  output logic [ptcwd_pkg::TAP_N-1:0] ch0TapSel,
  output logic [ptcwd_pkg::TAP_N-1:0] ch1TapSel,
  output logic generalCallAccept
);

  // Effective switch state of one channel from its stored nibble.
  function automatic ptcwd_pkg::ptcwd_switch_type chan_switch(
    input ptcwd_pkg::ptcwd_chan_type f, input logic present);
    ptcwd_pkg::ptcwd_switch_type s;
    s = '0;
    if (!present) begin
      s = '0;
    end else if (!f.shutdownRelease) begin
      s.termA = 1'b0;
      s.wiper = 1'b1;
      s.termB = 1'b1;
      s.tapZero = 1'b1;
    end else begin
      s.termA = f.termAConnect;
      s.wiper = f.wiperConnect;
      s.termB = f.termBConnect;
      s.tapZero = 1'b0;
    end
    chan_switch = s;
  endfunction : chan_switch

  // Brown-out pin synchroniser; the first stage feeds only the second.
  logic [ptcwd_pkg::SYNC_STAGES-1:0] borSync_q;
  logic [ptcwd_pkg::SYNC_STAGES-1:0] borSync_d;
  logic borLevel_q;
  logic borLevel_d;
  logic borRise;

  always_comb begin
    borSync_d = {borSync_q[1:0], brownoutResetEvent};
    borLevel_d = borLevel_q;
    if (borSync_q[1] == borSync_q[2]) begin
      borLevel_d = borSync_q[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      borSync_q <= '0;
      borLevel_q <= 1'b0;
    end else if (ce) begin
      borSync_q <= borSync_d;
      borLevel_q <= borLevel_d;
    end
  end

  assign borRise = borLevel_d && !borLevel_q;

  // Register state: applied image, staged write and read return.
  ptcwd_pkg::ptcwd_tc_type tc_q;
  ptcwd_pkg::ptcwd_tc_type tc_d;
  ptcwd_pkg::ptcwd_tc_type stage_q;
  ptcwd_pkg::ptcwd_tc_type stage_d;
  ptcwd_pkg::ptcwd_tc_type wrImage;
  logic pending_q;
  logic pending_d;
  logic rdValid_q;
  logic rdValid_d;
  logic [ptcwd_pkg::TC_W-1:0] rdData_q;
  logic [ptcwd_pkg::TC_W-1:0] rdData_d;
  logic hitWrite;

  // Writes are staged and only reach the terminals at command completion, so a
  // half-received command never glitches the analog switches.
  always_comb begin
    hitWrite = cmdValid && cmdWrite && cmdAddr == ptcwd_pkg::TERMINAL_CONTROL_ADDR;
    stage_d = hitWrite ? ptcwd_pkg::ptcwd_tc_type'(cmdWrData) : stage_q;
    pending_d = pending_q;
    tc_d = tc_q;
    wrImage = hitWrite ? ptcwd_pkg::ptcwd_tc_type'(cmdWrData) : stage_q;
    if (borRise) begin
      tc_d = ptcwd_pkg::ptcwd_tc_type'(ptcwd_pkg::TERMINAL_CONTROL_RESET);
      pending_d = 1'b0;
    end else if (cmdDone && (pending_q || hitWrite)) begin
      tc_d.generalCallEnable = wrImage.generalCallEnable;
      if (!ch1Lock) begin
        tc_d.ch1 = wrImage.ch1;
      end
      if (!ch0Lock) begin
        tc_d.ch0 = wrImage.ch0;
      end
      pending_d = 1'b0;
    end else if (hitWrite) begin
      pending_d = 1'b1;
    end
    rdValid_d = cmdValid && !cmdWrite;
    rdData_d = rdData_q;
    if (cmdValid && !cmdWrite) begin
      rdData_d = (cmdAddr == ptcwd_pkg::TERMINAL_CONTROL_ADDR) ? tc_q : '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tc_q <= ptcwd_pkg::ptcwd_tc_type'(ptcwd_pkg::TERMINAL_CONTROL_RESET);
      stage_q <= ptcwd_pkg::ptcwd_tc_type'(ptcwd_pkg::TERMINAL_CONTROL_RESET);
      pending_q <= 1'b0;
      rdValid_q <= 1'b0;
      rdData_q <= '0;
    end else if (ce) begin
      tc_q <= tc_d;
      stage_q <= stage_d;
      pending_q <= pending_d;
      rdValid_q <= rdValid_d;
      rdData_q <= rdData_d;
    end
  end

  // Switch outputs are registered copies of the combinational decode.
  ptcwd_pkg::ptcwd_switch_type sw0_d;
  ptcwd_pkg::ptcwd_switch_type sw1_d;
  ptcwd_pkg::ptcwd_switch_type sw0_q;
  ptcwd_pkg::ptcwd_switch_type sw1_q;
  logic gca_q;
  logic gca_d;

  always_comb begin
    sw0_d = chan_switch(tc_q.ch0, 1'b1);
    sw1_d = chan_switch(tc_q.ch1, TWO_CHANNEL);
    gca_d = tc_q.generalCallEnable;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw0_q <= '0;
      sw1_q <= '0;
      gca_q <= 1'b0;
    end else if (ce) begin
      sw0_q <= sw0_d;
      sw1_q <= sw1_d;
      gca_q <= gca_d;
    end
  end

  // Tap decoders; shutdown parks the wiper on terminal B without touching the code.
  ptcwd_wiper_decode #(.EIGHT_BIT(EIGHT_BIT)) u_dec0 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wiperCode(ch0WiperCode),
    .forceZero(sw0_d.tapZero),
    .tapSel(ch0TapSel)
  );

  ptcwd_wiper_decode #(.EIGHT_BIT(EIGHT_BIT)) u_dec1 (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wiperCode(ch1WiperCode),
    .forceZero(sw1_d.tapZero),
    .tapSel(ch1TapSel)
  );

  assign ch0Switch = sw0_q;
  assign ch1Switch = sw1_q;
  assign generalCallAccept = gca_q;
  assign rdValid = rdValid_q;
  assign rdData = rdData_q;

  // A staged write followed by its completion strobe.
  sequence s_write_done;
    ce && cmdDone && pending_q && !borRise;
  endsequence

  a_hold_unfinished: assert property (@(posedge clk) disable iff (rst)
    ce && hitWrite && !cmdDone && !borRise |=> tc_q == $past(tc_q))
    else $error("terminal control changed before command completed");
  a_lock1_hold: assert property (@(posedge clk) disable iff (rst)
    s_write_done and ch1Lock |=> tc_q.ch1 == $past(tc_q.ch1))
    else $error("locked channel 1 fields were written");
  a_lock0_hold: assert property (@(posedge clk) disable iff (rst)
    s_write_done and ch0Lock |=> tc_q.ch0 == $past(tc_q.ch0))
    else $error("locked channel 0 fields were written");
  // A fresh write may land in the completion cycle, so compare with the applied image.
  a_unlock_apply: assert property (@(posedge clk) disable iff (rst)
    s_write_done and !ch0Lock |=> tc_q.ch0 == $past(wrImage.ch0))
    else $error("unlocked channel 0 write not applied");
  a_bor_reload: assert property (@(posedge clk) disable iff (rst)
    ce && borRise |=> tc_q == ptcwd_pkg::TERMINAL_CONTROL_RESET)
    else $error("brown-out did not reload terminal control");
  a_shutdown_force: assert property (@(posedge clk) disable iff (rst)
    ce && !tc_q.ch0.shutdownRelease |=> !sw0_q.termA && sw0_q.wiper && sw0_q.termB)
    else $error("channel 0 shutdown state wrong");
  a_fields_govern: assert property (@(posedge clk) disable iff (rst)
    ce && tc_q.ch0.shutdownRelease |=>
    sw0_q.termA == $past(tc_q.ch0.termAConnect) && sw0_q.termB == $past(tc_q.ch0.termBConnect))
    else $error("channel 0 connect fields not governing");
  a_gca_follow: assert property (@(posedge clk) disable iff (rst)
    ce |=> generalCallAccept == $past(tc_q.generalCallEnable))
    else $error("general call acceptance does not follow enable bit");
  a_single_idle: assert property (@(posedge clk) disable iff (rst)
    ce && !TWO_CHANNEL |=> ch1Switch == 4'h0)
    else $error("absent channel 1 switches not idle");

endmodule : ptcwd_top
`default_nettype wire

// [verilog/ptcwd_pkg.sv]
// Purpose: Shared constants and types for the terminal control and wiper decode block.
// Assumes: One system clock; register access through a serial command front end.
// Notes: Field positions follow the nine-bit terminal control layout.
package ptcwd_pkg;

  // Register addresses seen on the command port.
  localparam logic [3:0] TERMINAL_CONTROL_ADDR = 4'h4;
  localparam int ADDR_W = 4;
  localparam int TC_W = 9;
  localparam int CODE_W = 10;
  localparam int TAP_N = 257;

  // Value after power-on or brown-out reset: all terminals connected, general call on.
  localparam logic [8:0] TERMINAL_CONTROL_RESET = 9'h1FF;

  // Field positions inside the register.
  localparam int GCE_POS = 8;
  localparam int CH1_LSB = 4;
  localparam int CH0_LSB = 0;

  // Full-scale wiper codes per resolution.
  localparam logic [9:0] FULL_SCALE_8BIT = 10'h100;
  localparam logic [9:0] FULL_SCALE_7BIT = 10'h080;
  localparam logic [9:0] ZERO_SCALE = 10'h000;

  // Pin synchroniser depth.
  localparam int SYNC_STAGES = 3;

  // One channel nibble, high to low.
  typedef struct packed {
    logic shutdownRelease;
    logic termAConnect;
    logic wiperConnect;
    logic termBConnect;
  } ptcwd_chan_type;

  // Whole register image.
  typedef struct packed {
    logic generalCallEnable;
    ptcwd_chan_type ch1;
    ptcwd_chan_type ch0;
  } ptcwd_tc_type;

  // Effective switch state driven to one resistor network.
  typedef struct packed {
    logic termA;
    logic wiper;
    logic termB;
    logic tapZero;
  } ptcwd_switch_type;

endpackage : ptcwd_pkg

// [verilog/ptcwd_wiper_decode.sv]
// Purpose: Decode a volatile wiper code into a one-of-N ladder tap selection.
// Assumes: Code comes from logic on the same clock.
// Notes: Tap 0 is terminal B, the full-scale tap is terminal A.
`timescale 1ns/100ps
`default_nettype none
module ptcwd_wiper_decode #(
  parameter bit EIGHT_BIT = 1'b1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Code and shutdown override.
  input wire logic [ptcwd_pkg::CODE_W-1:0] wiperCode,
  input wire logic forceZero,
  // Registered one-hot tap selection.
  output logic [ptcwd_pkg::TAP_N-1:0] tapSel
);

  // Saturate the code at the full-scale tap of the chosen resolution.
  function automatic logic [8:0] tap_index(input logic [9:0] code);
    logic [9:0] fs;
    fs = ptcwd_pkg::FULL_SCALE_8BIT;
    if (!EIGHT_BIT) begin
      fs = ptcwd_pkg::FULL_SCALE_7BIT;
    end
    tap_index = code[8:0];
    if (code >= fs) begin
      tap_index = fs[8:0];
    end
  endfunction : tap_index

  logic [ptcwd_pkg::TAP_N-1:0] tapSel_d;
  logic [ptcwd_pkg::TAP_N-1:0] tapSel_q;

  // Exactly one tap is closed; shutdown parks the wiper on terminal B.
  always_comb begin
    tapSel_d = '0;
    if (forceZero) begin
      tapSel_d[0] = 1'b1;
    end else begin
      tapSel_d[tap_index(wiperCode)] = 1'b1;
    end
  end

  // Reset parks the wiper at zero scale until the first enabled edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tapSel_q <= {{(ptcwd_pkg::TAP_N-1){1'b0}}, 1'b1};
    end else if (ce) begin
      tapSel_q <= tapSel_d;
    end
  end

  assign tapSel = tapSel_q;

  a_tap_onehot: assert property (@(posedge clk) disable iff (rst) $onehot(tapSel_q))
    else $error("tap selection is not one-hot");
  a_tap_zero: assert property (@(posedge clk) disable iff (rst)
    ce && !forceZero && wiperCode == 10'h000 |=> tapSel_q[0])
    else $error("zero code did not select terminal B");
  a_tap_full: assert property (@(posedge clk) disable iff (rst)
    ce && !forceZero && wiperCode >= 10'h100 && EIGHT_BIT |=> tapSel_q[256])
    else $error("code above full scale did not select terminal A");
  a_tap_full_seven: assert property (@(posedge clk) disable iff (rst)
    ce && !forceZero && wiperCode >= 10'h080 && !EIGHT_BIT |=> tapSel_q[128])
    else $error("code above seven-bit full scale did not select terminal A");

endmodule : ptcwd_wiper_decode
`default_nettype wire

// [tb/ptcwd_host_model.sv]
// Purpose: Host controller model that drives the command port.
// Assumes: Commands launch on the falling clock edge, one slot each.
// Notes: Released data lines carry the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module ptcwd_host_model (
  // Clock.
  input wire logic clk,
  // Command port.
  output logic cmdValid,
  output logic cmdWrite,
  output logic [ptcwd_pkg::ADDR_W-1:0] cmdAddr,
  output logic [ptcwd_pkg::TC_W-1:0] cmdWrData,
  output logic cmdDone,
  // Read answer.
  input wire logic rdValid,
  input wire logic [ptcwd_pkg::TC_W-1:0] rdData
);
  // Idle port at time zero.
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 4'h0;
    cmdWrData = 9'h000;
    cmdDone = 1'b0;
  end

  // One command cycle; the answer is taken one cycle after the request.
  task automatic slot(input logic v, input logic w, input logic [3:0] a,
      input logic [8:0] d, input logic dn, output logic [9:0] rd);
    @(negedge clk);
    cmdValid = v;
    cmdWrite = w;
    cmdAddr = a;
    cmdWrData = d;
    cmdDone = dn;
    @(negedge clk);
    rd = {rdValid, rdData};
    cmdValid = 1'b0;
    cmdDone = 1'b0;
    cmdAddr = ~a;
    cmdWrData = ~d;
  endtask : slot
endmodule : ptcwd_host_model
`default_nettype wire

// [tb/pot_terminal_control_and_wiper_decode_test.sv]
// Purpose: Self-checking bench for the terminal control block.
// Assumes: Two-channel eight-bit main unit plus a single-channel seven-bit variant, inputs change on falling edges.
// Notes: Random traffic is seeded once so a failure can be replayed.
`timescale 1ns/100ps
`default_nettype none
module pot_terminal_control_and_wiper_decode_test;
  logic clk, rst, ce, bor, cmdValid, cmdWrite, cmdDone, rdValid, gca, l0, l1;
  logic [3:0] cmdAddr;
  logic [8:0] cmdWrData, rdData;
  logic [9:0] code0, code1, rd;
  logic [9:0] tbl [7] = '{10'h000, 10'h001, 10'h080, 10'h0FF, 10'h100, 10'h101, 10'h3FF};
  ptcwd_pkg::ptcwd_switch_type sw0, sw1, sw0s, sw1s;
  logic [256:0] tap0, tap1, tap0s;
  ptcwd_pkg::ptcwd_tc_type tcExp;
  int errTotal = 0;
  int nTests = 0;

  ptcwd_top #(.TWO_CHANNEL(1'b1), .EIGHT_BIT(1'b1)) uut (.clk(clk), .rst(rst), .ce(ce),
    .brownoutResetEvent(bor), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdWrData(cmdWrData), .cmdDone(cmdDone), .rdValid(rdValid), .rdData(rdData),
    .ch0Lock(l0), .ch1Lock(l1), .ch0WiperCode(code0), .ch1WiperCode(code1),
    .ch0Switch(sw0), .ch1Switch(sw1), .ch0TapSel(tap0), .ch1TapSel(tap1),
    .generalCallAccept(gca));
  ptcwd_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdDone(cmdDone), .rdValid(rdValid),
    .rdData(rdData));
  // Single-channel seven-bit variant sees the same traffic as the main unit.
  ptcwd_top #(.TWO_CHANNEL(1'b0), .EIGHT_BIT(1'b0)) uutSmall (.clk(clk), .rst(rst), .ce(ce),
    .brownoutResetEvent(bor), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdWrData(cmdWrData), .cmdDone(cmdDone), .rdValid(), .rdData(),
    .ch0Lock(l0), .ch1Lock(l1), .ch0WiperCode(code0), .ch1WiperCode(code1),
    .ch0Switch(sw0s), .ch1Switch(sw1s), .ch0TapSel(tap0s), .ch1TapSel(),
    .generalCallAccept());

  // Shutdown wins over the connect fields, which stay stored.
  function automatic ptcwd_pkg::ptcwd_switch_type swOf(ptcwd_pkg::ptcwd_chan_type f);
    if (!f.shutdownRelease) return 4'h7;
    return {f.termAConnect, f.wiperConnect, f.termBConnect, 1'b0};
  endfunction : swOf

  // One-hot tap, saturating at the terminal A end given by the full-scale code.
  function automatic logic [256:0] tapOf(ptcwd_pkg::ptcwd_chan_type f, logic [9:0] c, int fs);
    logic [256:0] t;
    t = '0;
    if (!f.shutdownRelease) t[0] = 1'b1;
    else t[(c > fs) ? fs : c] = 1'b1;
    return t;
  endfunction : tapOf

  // A locked nibble keeps its old value; the enable bit always follows.
  function automatic ptcwd_pkg::ptcwd_tc_type nextTc(ptcwd_pkg::ptcwd_tc_type o,
      logic [8:0] d, logic k0, logic k1);
    ptcwd_pkg::ptcwd_tc_type n;
    n = d;
    if (k1) n.ch1 = o.ch1;
    if (k0) n.ch0 = o.ch0;
    return n;
  endfunction : nextTc

  task automatic chk(input string n, input logic [256:0] e, input logic [256:0] g);
    nTests++;
    if (g !== e) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chkAll();
    chk("ch0Switch", swOf(tcExp.ch0), sw0);
    chk("ch1Switch", swOf(tcExp.ch1), sw1);
    chk("ch0TapSel", tapOf(tcExp.ch0, code0, ptcwd_pkg::FULL_SCALE_8BIT), tap0);
    chk("ch1TapSel", tapOf(tcExp.ch1, code1, ptcwd_pkg::FULL_SCALE_8BIT), tap1);
    chk("generalCallAccept", tcExp.generalCallEnable, gca);
    chk("small ch0Switch", swOf(tcExp.ch0), sw0s);
    chk("small ch1Switch", 4'h0, sw1s);
    chk("small ch0TapSel", tapOf(tcExp.ch0, code0, ptcwd_pkg::FULL_SCALE_7BIT), tap0s);
  endtask : chkAll

  task automatic rdChk(input logic [3:0] a, input logic [8:0] e);
    host.slot(1'b1, 1'b0, a, 9'h000, 1'b0, rd);
    chk("rdValid", 1'b1, rd[9]);
    chk("rdData", e, rd[8:0]);
  endtask : rdChk

  // Write, optionally holding completion back to check nothing applies early.
  task automatic wr(input logic [8:0] d, input int gap);
    host.slot(1'b1, 1'b1, 4'h4, d, gap == 0, rd);
    if (gap > 0) begin
      repeat (gap) @(negedge clk);
      chkAll();
      host.slot(1'b0, 1'b0, 4'h0, 9'h000, 1'b1, rd);
    end
    tcExp = nextTc(tcExp, d, l0, l1);
    repeat (2) @(negedge clk);
    chkAll();
  endtask : wr

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Watchdog sized well above the expected run of several hundred cycles.
  initial begin
    #(100 * 20000);
    errTotal++;
    wrap_up();
  end

  // Main sequence: reset values, lock corners, random traffic, brown-out.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bor = 1'b0;
    l0 = 1'b0;
    l1 = 1'b0;
    code0 = 10'h000;
    code1 = 10'h000;
    tcExp = 9'h1FF;
    void'($urandom(52901));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chkAll();
    rdChk(4'h4, 9'h1FF);
    for (int k = 0; k < 4; k++) begin
      l0 = k[0];
      l1 = k[1];
      wr(9'h0A5 ^ {9{k[0]}}, 0);
    end
    // A low clock enable must swallow a complete unlocked write.
    l0 = 1'b0;
    l1 = 1'b0;
    ce = 1'b0;
    host.slot(1'b1, 1'b1, 4'h4, 9'h000, 1'b1, rd);
    repeat (2) @(negedge clk);
    chkAll();
    ce = 1'b1;
    rdChk(4'h4, tcExp);
    code0 = 10'h05A;
    l0 = 1'b0;
    l1 = 1'b0;
    wr(9'h1F7, 0);
    wr(9'h1FF, 3);
    for (int i = 0; i < 60; i++) begin
      code0 = (i < 7) ? tbl[i] : 10'($urandom_range(0, 1023));
      code1 = (i < 7) ? tbl[6 - i] : 10'($urandom_range(0, 1023));
      l0 = 1'($urandom_range(0, 1));
      l1 = 1'($urandom_range(0, 1));
      wr(9'($urandom), 3 * $urandom_range(0, 1));
      rdChk(4'h4, tcExp);
    end
    host.slot(1'b1, 1'b1, 4'h3, 9'h000, 1'b1, rd);
    repeat (2) @(negedge clk);
    chkAll();
    rdChk(4'h3, 9'h000);
    l0 = 1'b0;
    l1 = 1'b0;
    wr(9'h0AA, 0);
    bor = 1'b1;
    repeat (3) @(negedge clk);
    bor = 1'b0;
    repeat (6) @(negedge clk);
    tcExp = 9'h1FF;
    chkAll();
    rdChk(4'h4, 9'h1FF);
    wr(9'h155, 0);
    wrap_up();
  end
endmodule : pot_terminal_control_and_wiper_decode_test
`default_nettype wire
